// *** sac_pkg.sv ***
package sac_pkg;
  // ==========================================================================
  // Register map
  // Printed offset 0x310c9 is not a multiple of four: it is kept as an index
  localparam logic [19:0] TALLY_INDEX      = 20'h310c9;
  localparam int          ADDR_W           = 22;
  localparam logic [21:0] TALLY_LO_ADDR    = {TALLY_INDEX, 2'b00};
  localparam logic [21:0] TALLY_HI_ADDR    = 22'h000104;
  localparam logic [21:0] MODE_ADDR        = 22'h000000;
  localparam logic [21:0] DEPTH_LO_ADDR    = 22'h000008;
  localparam logic [21:0] DEPTH_HI_ADDR    = 22'h00000c;
  localparam logic [21:0] POST_LO_ADDR     = 22'h000010;
  localparam logic [21:0] POST_HI_ADDR     = 22'h000014;
  localparam logic [21:0] SEG_LO_ADDR      = 22'h000018;
  localparam logic [21:0] SEG_HI_ADDR      = 22'h00001c;
  localparam logic [21:0] REPEAT_ADDR      = 22'h000020;
  localparam logic [21:0] CTRL_ADDR        = 22'h000024;
  localparam logic [21:0] STATUS_ADDR      = 22'h000028;
  localparam logic [21:0] PRE_LO_ADDR      = 22'h00002c;
  // ==========================================================================
  // Field values
  localparam logic [31:0] MODE_STD_MULTI   = 32'h00000002;
  localparam logic [31:0] MODE_FIFO_MULTI  = 32'h00000020;
  localparam int          CTRL_START_BIT   = 0;
  localparam int          CTRL_STOP_BIT    = 1;
  localparam int          CTRL_TWO_CH_BIT  = 2;
  localparam int          CTRL_TS_EN_BIT   = 3;
  localparam int          ST_RUN_BIT       = 0;
  localparam int          ST_ERR_BIT       = 1;
  localparam int          ST_DONE_BIT      = 2;
  // ==========================================================================
  // Limits, in samples; sample size in bytes; bus responses; reset word
  localparam int          SAMPLE_BYTES     = 2;
  localparam logic [35:0] STEP             = 36'h000000008;
  localparam logic [35:0] MIN_DEPTH        = 36'h000000010;
  localparam logic [35:0] MIN_POST         = 36'h000000008;
  localparam logic [35:0] MAX_POST         = 36'h1fffffff8;
  localparam logic [35:0] MIN_PRE          = 36'h000000008;
  localparam logic [35:0] MAX_PRE_ONE      = 36'h000002000;
  localparam logic [35:0] MAX_PRE_TWO      = 36'h000001000;
  localparam logic [35:0] MIN_SEG          = 36'h000000010;
  localparam logic [35:0] MAX_SEG_FIFO     = 36'h1fffffff8;
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;
  localparam logic [31:0] RESET_WORD       = 32'h00000000;
endpackage

// *** sac_fifo.sv ***
`timescale 1ns/1ps
module sac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             do_wr;
  logic             do_rd;
  logic             full;
  logic             empty;
  assign full      = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign empty     = (wr_reg == rd_reg);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign do_wr     = in_valid && !full;
  assign do_rd     = out_ready && !empty;
  assign out_data  = mem[rd_reg[AW-1:0]];
  always_ff @(posedge aclk) begin
    if (do_wr) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_reg + (AW+1)'(do_wr);
      rd_reg <= rd_reg + (AW+1)'(do_rd);
    end
  end
endmodule // sac_fifo

// *** sac_limit_check.sv ***
`timescale 1ns/1ps
module sac_limit_check (
  // Value and its window
  input  wire logic [35:0] value,
  input  wire logic [35:0] lo,
  input  wire logic [35:0] hi,
  // Verdict
  output logic             ok
);
  // Inside the window and on the 8-sample grid
  assign ok = (value >= lo) && (value <= hi) && (value[2:0] == 3'h0);
endmodule // sac_limit_check

// *** sac_acq_ctrl.sv ***
`timescale 1ns/1ps
module sac_acq_ctrl #(
  parameter logic [35:0] MEM_SAMPLES = 36'h008000000,
  parameter int          TS_W        = 64,
  parameter int          FIFO_DEPTH  = 16
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [21:0]       s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic      [1:0]        s_axi_bresp,
  // AXI4-Lite read
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [21:0]       s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  // Trigger inputs
  input  wire logic              trig_hw,
  input  wire logic              trig_sw,
  input  wire logic              trig_force,
  input  wire logic [TS_W-1:0]   sample_time,
  // Segment events
  output logic                   seg_start,
  output logic      [35:0]       seg_first_offset,
  // Timestamp stream
  output logic                   ts_valid,
  input  wire logic              ts_ready,
  output logic      [TS_W-1:0]   ts_data
);
  // ==========================================================================
  // State
  typedef enum logic [1:0] {SAC_IDLE, SAC_ARMED, SAC_FILL} sac_state_e;
  sac_state_e  state_reg;
  logic [31:0] mode_reg;
  logic [35:0] depth_reg;
  logic [35:0] post_reg;
  logic [35:0] seg_reg;
  logic [31:0] repeat_reg;
  logic [3:0]  ctrl_reg;
  logic        err_reg;
  logic        done_reg;
  logic [47:0] tally_reg;
  logic [15:0] tally_hi_reg;
  logic [35:0] fill_reg;
  logic [35:0] written_reg;
  logic [31:0] segs_reg;
  // ==========================================================================
  // Limit checks
  logic        two_ch;
  logic        std_m;
  logic        fifo_m;
  logic [35:0] pre_len;
  logic [35:0] depth_max;
  logic [35:0] pre_max;
  logic [35:0] seg_max;
  logic        ok_depth;
  logic        ok_post;
  logic        ok_pre;
  logic        ok_seg;
  logic        ok_mult;
  logic        cfg_ok;
  assign two_ch    = ctrl_reg[sac_pkg::CTRL_TWO_CH_BIT];
  assign std_m     = (mode_reg == sac_pkg::MODE_STD_MULTI);
  assign fifo_m    = (mode_reg == sac_pkg::MODE_FIFO_MULTI);
  assign pre_len   = seg_reg - post_reg;
  assign depth_max = two_ch ? (MEM_SAMPLES >> 1) : MEM_SAMPLES;
  assign pre_max   = two_ch ? sac_pkg::MAX_PRE_TWO : sac_pkg::MAX_PRE_ONE;
  assign seg_max   = fifo_m ? sac_pkg::MAX_SEG_FIFO
                   : (two_ch ? (MEM_SAMPLES >> 2) : (MEM_SAMPLES >> 1));
  assign ok_mult   = fifo_m || (seg_reg != 36'h0 && (depth_reg % seg_reg) == 36'h0);
  sac_limit_check u_chk_depth (
    .value (depth_reg),
    .lo    (sac_pkg::MIN_DEPTH),
    .hi    (depth_max),
    .ok    (ok_depth)
  );
  sac_limit_check u_chk_post (
    .value (post_reg),
    .lo    (sac_pkg::MIN_POST),
    .hi    (std_m ? seg_max : sac_pkg::MAX_POST),
    .ok    (ok_post)
  );
  sac_limit_check u_chk_pre (
    .value (pre_len),
    .lo    (sac_pkg::MIN_PRE),
    .hi    (pre_max),
    .ok    (ok_pre)
  );
  sac_limit_check u_chk_seg (
    .value (seg_reg),
    .lo    (sac_pkg::MIN_SEG),
    .hi    (seg_max),
    .ok    (ok_seg)
  );
  assign cfg_ok = (std_m || fifo_m) && ok_post && ok_pre && ok_seg && (seg_reg > post_reg)
                && (fifo_m || (ok_depth && ok_mult));
  // ==========================================================================
  // AXI4-Lite write path
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [21:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        do_write;
  logic [31:0] wmask;
  logic        wr_known;
  logic        start_cmd;
  logic        stop_cmd;
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign do_write      = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wmask         = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_known      = (aw_addr_reg == sac_pkg::MODE_ADDR)     || (aw_addr_reg == sac_pkg::DEPTH_LO_ADDR)
                      || (aw_addr_reg == sac_pkg::DEPTH_HI_ADDR) || (aw_addr_reg == sac_pkg::POST_LO_ADDR)
                      || (aw_addr_reg == sac_pkg::POST_HI_ADDR)  || (aw_addr_reg == sac_pkg::SEG_LO_ADDR)
                      || (aw_addr_reg == sac_pkg::SEG_HI_ADDR)   || (aw_addr_reg == sac_pkg::REPEAT_ADDR)
                      || (aw_addr_reg == sac_pkg::CTRL_ADDR);
  assign start_cmd     = do_write && (aw_addr_reg == sac_pkg::CTRL_ADDR) && w_strb_reg[0]
                      && w_data_reg[sac_pkg::CTRL_START_BIT];
  assign stop_cmd      = do_write && (aw_addr_reg == sac_pkg::CTRL_ADDR) && w_strb_reg[0]
                      && w_data_reg[sac_pkg::CTRL_STOP_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= sac_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[21:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_known ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  // Parameters are frozen while an acquisition runs
  logic cfg_wr;
  assign cfg_wr = do_write && (state_reg == SAC_IDLE);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg   <= sac_pkg::RESET_WORD;
      depth_reg  <= '0;
      post_reg   <= '0;
      seg_reg    <= '0;
      repeat_reg <= sac_pkg::RESET_WORD;
    end else if (cfg_wr) begin
      case (aw_addr_reg)
        sac_pkg::MODE_ADDR:     mode_reg         <= (mode_reg & ~wmask) | (w_data_reg & wmask);
        sac_pkg::DEPTH_LO_ADDR: depth_reg[31:0]  <= (depth_reg[31:0] & ~wmask) | (w_data_reg & wmask);
        sac_pkg::DEPTH_HI_ADDR: depth_reg[35:32] <= w_strb_reg[0] ? w_data_reg[3:0] : depth_reg[35:32];
        sac_pkg::POST_LO_ADDR:  post_reg[31:0]   <= (post_reg[31:0] & ~wmask) | (w_data_reg & wmask);
        sac_pkg::POST_HI_ADDR:  post_reg[35:32]  <= w_strb_reg[0] ? w_data_reg[3:0] : post_reg[35:32];
        sac_pkg::SEG_LO_ADDR:   seg_reg[31:0]    <= (seg_reg[31:0] & ~wmask) | (w_data_reg & wmask);
        sac_pkg::SEG_HI_ADDR:   seg_reg[35:32]   <= w_strb_reg[0] ? w_data_reg[3:0] : seg_reg[35:32];
        sac_pkg::REPEAT_ADDR:   repeat_reg       <= (repeat_reg & ~wmask) | (w_data_reg & wmask);
        default: ;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= '0;
    end else if (cfg_wr && aw_addr_reg == sac_pkg::CTRL_ADDR && w_strb_reg[0]) begin
      ctrl_reg <= {w_data_reg[sac_pkg::CTRL_TS_EN_BIT], w_data_reg[sac_pkg::CTRL_TWO_CH_BIT], 2'b00};
    end
  end
  // ==========================================================================
  // Acquisition sequencer
  logic        trig_ok;
  logic        take_trig;
  logic        seg_end;
  logic        depth_full;
  logic        count_met;
  logic        ts_in_ready;
  assign trig_ok    = trig_hw || trig_force;
  assign take_trig  = (state_reg == SAC_ARMED) && trig_ok
                   && (!ctrl_reg[sac_pkg::CTRL_TS_EN_BIT] || ts_in_ready);
  assign seg_end    = (state_reg == SAC_FILL) && (fill_reg == post_reg - 36'h1);
  assign depth_full = std_m && (written_reg + seg_reg >= depth_reg);
  assign count_met  = fifo_m && (repeat_reg != 32'h0) && (segs_reg + 32'h1 >= repeat_reg);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= SAC_IDLE;
      fill_reg    <= '0;
      written_reg <= '0;
      segs_reg    <= '0;
      err_reg     <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      case (state_reg)
        SAC_IDLE: begin
          if (start_cmd) begin
            err_reg     <= !cfg_ok;
            done_reg    <= 1'b0;
            written_reg <= '0;
            segs_reg    <= '0;
            if (cfg_ok) begin
              state_reg <= SAC_ARMED;
            end
          end
        end
        SAC_ARMED: begin
          if (stop_cmd) begin
            state_reg <= SAC_IDLE;
            done_reg  <= 1'b1;
          end else if (take_trig) begin
            fill_reg  <= '0;
            state_reg <= SAC_FILL;
          end
        end
        SAC_FILL: begin
          fill_reg <= fill_reg + 36'h1;
          if (stop_cmd) begin
            state_reg <= SAC_IDLE;
            done_reg  <= 1'b1;
          end else if (seg_end) begin
            written_reg <= written_reg + seg_reg;
            segs_reg    <= segs_reg + 32'h1;
            if (depth_full || count_met) begin
              state_reg <= SAC_IDLE;
              done_reg  <= 1'b1;
            end else begin
              state_reg <= SAC_ARMED;
            end
          end
        end
        default: state_reg <= SAC_IDLE;
      endcase
    end
  end
  // ==========================================================================
  // Trigger tally and segment outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tally_reg <= '0;
    end else if (state_reg == SAC_IDLE && start_cmd) begin
      tally_reg <= '0;
    end else if (take_trig) begin
      tally_reg <= tally_reg + 48'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg_start        <= 1'b0;
      seg_first_offset <= '0;
    end else begin
      seg_start        <= take_trig;
      seg_first_offset <= take_trig ? written_reg : seg_first_offset;
    end
  end
  // Timestamp of the trigger sample itself; segment start is pre_len earlier
  sac_fifo #(
    .WIDTH (TS_W),
    .DEPTH (FIFO_DEPTH)
  ) u_ts_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (take_trig && ctrl_reg[sac_pkg::CTRL_TS_EN_BIT]),
    .in_ready  (ts_in_ready),
    .in_data   (sample_time),
    .out_valid (ts_valid),
    .out_ready (ts_ready),
    .out_data  (ts_data)
  );
  // ==========================================================================
  // AXI4-Lite read path
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_word;
  logic        rd_known;
  logic [21:0] ra;
  assign ra            = {s_axi_araddr[21:2], 2'b00};
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  always_comb begin
    rd_known = 1'b1;
    case (ra)
      sac_pkg::MODE_ADDR:     rd_word = mode_reg;
      sac_pkg::DEPTH_LO_ADDR: rd_word = depth_reg[31:0];
      sac_pkg::DEPTH_HI_ADDR: rd_word = {28'h0, depth_reg[35:32]};
      sac_pkg::POST_LO_ADDR:  rd_word = post_reg[31:0];
      sac_pkg::POST_HI_ADDR:  rd_word = {28'h0, post_reg[35:32]};
      sac_pkg::SEG_LO_ADDR:   rd_word = seg_reg[31:0];
      sac_pkg::SEG_HI_ADDR:   rd_word = {28'h0, seg_reg[35:32]};
      sac_pkg::REPEAT_ADDR:   rd_word = repeat_reg;
      sac_pkg::CTRL_ADDR:     rd_word = {28'h0, ctrl_reg};
      sac_pkg::STATUS_ADDR:   rd_word = {29'h0, done_reg, err_reg, state_reg != SAC_IDLE};
      sac_pkg::PRE_LO_ADDR:   rd_word = pre_len[31:0];
      sac_pkg::TALLY_LO_ADDR: rd_word = tally_reg[31:0];
      sac_pkg::TALLY_HI_ADDR: rd_word = {16'h0, tally_hi_reg};
      default: begin
        rd_word  = 32'h0;
        rd_known = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg   <= 1'b0;
      rdata_reg    <= '0;
      rresp_reg    <= sac_pkg::RESP_OKAY;
      tally_hi_reg <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_known ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
      if (ra == sac_pkg::TALLY_LO_ADDR) begin
        tally_hi_reg <= tally_reg[47:32];
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule // sac_acq_ctrl

// *** sac_acq_ctrl_sva.sv ***
`timescale 1ns/1ps
module sac_acq_ctrl_sva #(
  parameter int TS_W = 64
) (
  // Clock and reset
  input wire logic            aclk,
  input wire logic            aresetn,
  // Register bus
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  // Triggers and timestamps
  input wire logic            trig_hw,
  input wire logic            trig_sw,
  input wire logic            trig_force,
  input wire logic            seg_start,
  input wire logic            ts_valid,
  input wire logic            ts_ready,
  input wire logic [TS_W-1:0] ts_data
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (wr_taken |=> wr_answer)
    else $error("write answer off time");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during answer");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  a_seg_pulse: assert property (seg_start |=> !seg_start)
    else $error("segment pulse too long");
  a_seg_cause: assert property (seg_start |-> $past(trig_hw || trig_force))
    else $error("segment without trigger");
  a_sw_ignored: assert property (trig_sw && !trig_hw && !trig_force |=> !seg_start)
    else $error("software trigger started segment");
  a_ts_hold: assert property (ts_valid && !ts_ready |=> ts_valid && $stable(ts_data))
    else $error("timestamp lost while stalled");
endmodule // sac_acq_ctrl_sva
bind sac_acq_ctrl sac_acq_ctrl_sva #(.TS_W(TS_W)) u_sva (.*);

// *** sac_host.sv ***
`timescale 1ns/1ps
module sac_host (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [21:0] s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  // Read channels
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic      [21:0] s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  // Answers are always accepted at once
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 80'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
  end
  task automatic wr(input logic [21:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ta;
    bit tw;
    bit ad;
    bit wd;
    {ad, wd} = 2'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      ad = ad || ta;
      wd = wd || tw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [21:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask
endmodule // sac_host

// *** segmented_acquisition_control_test.sv ***
`timescale 1ns/1ps
module segmented_acquisition_control_test;
  typedef struct packed {
    logic [3:0] ctl; logic [7:0] mode; logic [15:0] post; logic [15:0] seg; logic [15:0] depth; logic [1:0] st;
  } sac_row_s;
  logic        aclk, aresetn, trig_hw, trig_sw, trig_force, ts_ready, seg_start, ts_valid;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [21:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic [63:0] sample_time, ts_data;
  logic [35:0] seg_first_offset;
  logic [63:0] ts_q[$];
  int          err_total = 0;
  int          checks_done = 0;
  int          pulses = 0;
  // Ok rows report running, bad rows report a config error
  sac_row_s    rows[12] = '{
    '{4'h0, 8'h02, 16'h0010, 16'h0020, 16'h0040, 2'h1}, '{4'h0, 8'h02, 16'h0010, 16'h0024, 16'h0048, 2'h2},
    '{4'h0, 8'h02, 16'h0010, 16'h0088, 16'h0088, 2'h2}, '{4'h0, 8'h02, 16'h0010, 16'h0080, 16'h0100, 2'h1},
    '{4'h0, 8'h02, 16'h0010, 16'h0080, 16'h0180, 2'h2}, '{4'h4, 8'h02, 16'h0010, 16'h0048, 16'h0048, 2'h2},
    '{4'h4, 8'h02, 16'h0010, 16'h0040, 16'h0080, 2'h1}, '{4'h0, 8'h02, 16'h0010, 16'h0020, 16'h0048, 2'h2},
    '{4'h0, 8'h02, 16'h0020, 16'h0020, 16'h0040, 2'h2}, '{4'h0, 8'h20, 16'h0008, 16'h2008, 16'h0040, 2'h1},
    '{4'h0, 8'h20, 16'h0008, 16'h2010, 16'h0040, 2'h2}, '{4'h4, 8'h20, 16'h0008, 16'h1010, 16'h0040, 2'h2}};
  sac_acq_ctrl #(.MEM_SAMPLES(36'h000000100)) DUT (.*);
  sac_host u_host (.*);
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) sample_time <= sample_time + 64'h1;
  // Timestamp is taken one cycle before the segment pulse
  always @(negedge aclk) if (seg_start === 1'b1) begin
    pulses++;
    ts_q.push_back(sample_time - 64'h1);
  end
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [21:0] a, input logic [31:0] e);
    u_host.rd(a, rd_d, rd_r);
    chk(64'(rd_d), 64'(e));
  endtask
  task automatic cfg(input sac_row_s r);
    u_host.wr(sac_pkg::MODE_ADDR, {24'h0, r.mode}, rd_r);
    u_host.wr(sac_pkg::POST_LO_ADDR, {16'h0, r.post}, rd_r);
    u_host.wr(sac_pkg::SEG_LO_ADDR, {16'h0, r.seg}, rd_r);
    u_host.wr(sac_pkg::DEPTH_LO_ADDR, {16'h0, r.depth}, rd_r);
    u_host.wr(sac_pkg::REPEAT_ADDR, 32'h0, rd_r);
    u_host.wr(sac_pkg::CTRL_ADDR, {28'h0, r.ctl}, rd_r);
    u_host.wr(sac_pkg::CTRL_ADDR, {28'h0, r.ctl | 4'h1}, rd_r);
  endtask
  task automatic fire(input bit frc);
    int n;
    n = pulses;
    if (frc) trig_force <= 1'b1;
    else trig_hw <= 1'b1;
    for (int i = 0; i < 50 && pulses == n; i++) @(posedge aclk);
    trig_force <= 1'b0;
    trig_hw <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    {aclk, aresetn, trig_hw, trig_sw, trig_force, ts_ready} = 6'h0;
    sample_time = 64'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(sac_pkg::TALLY_LO_ADDR, 32'h0);
    rdc(sac_pkg::STATUS_ADDR, 32'h0);
    rdc(22'h000030, 32'h0);
    chk(64'(rd_r), 64'(sac_pkg::RESP_SLVERR));
    u_host.wr(sac_pkg::TALLY_LO_ADDR, 32'h0000005a, rd_r);
    chk(64'(rd_r), 64'(sac_pkg::RESP_SLVERR));
    rdc(sac_pkg::TALLY_LO_ADDR, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      cfg(rows[i]);
      u_host.rd(sac_pkg::STATUS_ADDR, rd_d, rd_r);
      chk(64'(rd_d[1:0]), 64'(rows[i].st));
      u_host.wr(sac_pkg::CTRL_ADDR, 32'h2, rd_r);
    end
    $display("test limits done");
    cfg('{4'h8, 8'h20, 16'h0010, 16'h0020, 16'h0040, 2'h1});
    trig_sw <= 1'b1;
    repeat (4) @(posedge aclk);
    trig_sw <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(64'(pulses), 64'h0);
    fire(1'b1);
    repeat (15) fire(1'b0);
    chk(64'(pulses), 64'h10);
    fire(1'b0);
    chk(64'(pulses), 64'h10);
    chk(64'(seg_first_offset), 64'h1e0);
    rdc(sac_pkg::TALLY_LO_ADDR, 32'h10);
    rdc(sac_pkg::TALLY_HI_ADDR, 32'h0);
    ts_ready <= 1'b1;
    repeat (40) begin
      @(negedge aclk);
      if (ts_valid === 1'b1 && ts_q.size() > 0) chk(ts_data, ts_q.pop_front());
    end
    chk(64'(ts_q.size()), 64'h0);
    @(posedge aclk);
    u_host.wr(sac_pkg::CTRL_ADDR, 32'h2, rd_r);
    u_host.wr(sac_pkg::REPEAT_ADDR, 32'h2, rd_r);
    u_host.wr(sac_pkg::CTRL_ADDR, 32'h1, rd_r);
    rdc(sac_pkg::TALLY_LO_ADDR, 32'h0);
    repeat (2) fire(1'b0);
    repeat (20) @(posedge aclk);
    rdc(sac_pkg::STATUS_ADDR, 32'h4);
    rdc(sac_pkg::TALLY_LO_ADDR, 32'h2);
    u_host.wr(sac_pkg::CTRL_ADDR, 32'h2, rd_r);
    $display("test triggers done");
    complete_run();
  end
  initial begin
    #400000;
    err_total++;
    $display("[ERR] %0t timeout", $time);
    complete_run();
  end
endmodule // segmented_acquisition_control_test
